/* verilog/strap_override_status_regs.sv */
// Purpose: Indirect device-2 bank holding strap overrides, strap status and wake enables.
// Assumes: Management accesses arrive as decoded register strobes on core_clk.
// Notes:   Straps are sampled on every clock while rst_b is low; the last sample is kept.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Common-control bit 3 is the indicator style, 1 single, 0 dual colour, reset from strap.
// - Common-control bit 1 is the reference clock output enable, reset from strap.
// - Strap-status bit 7 reads the latched indicator style strap, read only.
// - Strap-status bit 5 reads the latched reference clock strap, read only.
// - Strap-status bits 2:0 read the strapped station address, whose bits 4:3 are always zero.
// - Override bit 10 enables wake on the interrupt/wake pin with the select field, reset 0.
// - Override bit 8 enables wake on the indicator/wake pin with the select field, reset 0.
// - Override bit 7 set forces chip power-down whatever the straps say.
// - Override bit 4 set forces pin-chain test mode whatever the straps say.
// - Override bit 1 set forces GMII/MII mode whatever the straps say.
// - Power-down, pin-chain and GMII/MII bits of both registers reset from the mode straps.
// - Mode-status bit 7 reads 1 when the straps chose chip power-down.
// - Mode-status bits 4 and 1 read 1 for strapped pin-chain test or GMII/MII, read only.
// - The wake select picks wake only, other only or both per shared pin; 11 is reserved.
module strap_override_status_regs
    import strap_bank_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire mgmt_req_t   mgmt_req,
    output logic [15:0]      mgmt_rdata,
    output logic             mgmt_rvalid,
    input  wire strap_pins_t strap_pins,
    input  wire logic        wake_req,
    input  wire logic        indicator_one_b,
    input  wire logic        intr_req_b,
    output logic             indicator_style_select,
    output logic             ref_clock_out_enable,
    output logic [4:0]       station_addr,
    output logic             chip_power_down,
    output logic             nand_tree_mode,
    output logic             gmii_mode,
    output logic             wake_event_out_a_b,
    output logic             wake_event_out_b_b
);

    // ************************
    // Helper functions.
    // ************************

    // Builds a 16-bit word with one bit placed at a position.
    function automatic logic [15:0] put_bit(input logic v, input int pos);
        logic [15:0] w;

        w = RESERVED_READ;
        w[pos] = v;
        return w;
    endfunction

    // True when the addressed device matches this bank.
    function automatic logic hits_bank(input logic [15:0] ctrl);
        return ctrl[PORTAL_DEV_HI:0] == BANK_DEVICE;
    endfunction

    // ************************
    // State.
    // ************************
    logic        style_q;
    logic        style_d;
    logic        refclk_q;
    logic        refclk_d;
    logic        wake_a_q;
    logic        wake_a_d;
    logic        wake_b_q;
    logic        wake_b_d;
    logic        pwrdn_q;
    logic        pwrdn_d;
    logic        nand_q;
    logic        nand_d;
    logic        gmii_q;
    logic        gmii_d;
    logic [1:0]  wake_sel_q;
    logic [1:0]  wake_sel_d;

    strap_pins_t strap_q;
    strap_pins_t strap_d;

    logic [15:0] pctrl_q;
    logic [15:0] pctrl_d;
    logic [15:0] pdata_q;
    logic [15:0] pdata_d;

    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;

    portal_mode_t mode;
    logic         data_mode;
    logic         bank_wr;
    logic         bank_rd;
    logic         st_pwrdn;
    logic         st_nand;
    logic         st_gmii;
    logic [15:0]  bank_word;

    // ************************
    // Portal decode.
    // ************************

    // Data moves only when the portal is in a data mode aimed at this device.
    always_comb begin
        mode      = portal_mode_t'(pctrl_q[PORTAL_MODE_HI:PORTAL_MODE_LO]);
        data_mode = (mode != PORTAL_ADDRESS);
        bank_wr   = mgmt_req.wr && (mgmt_req.addr == PORTAL_DATA_REG)
                    && data_mode && hits_bank(pctrl_q);
        bank_rd   = mgmt_req.rd && (mgmt_req.addr == PORTAL_DATA_REG)
                    && data_mode && hits_bank(pctrl_q);
    end

    // Strap-derived status bits come from the latched mode code only.
    always_comb begin
        st_pwrdn = (strap_q.mode == MODE_CODE_PWRDN);
        st_nand  = (strap_q.mode == MODE_CODE_NAND);
        st_gmii  = (strap_q.mode == MODE_CODE_GMII);
    end

    // ************************
    // Bank read mux.
    // ************************

    // Unimplemented offsets and reserved fields read as zero.
    always_comb begin
        bank_word = RESERVED_READ;

        if (pdata_q == COMMON_CONTROL_OFF) begin
            bank_word = put_bit(style_q, CC_STYLE_BIT)
                      | put_bit(refclk_q, CC_REFCLK_BIT);
        end else if (pdata_q == STRAP_STATUS_OFF) begin
            bank_word = put_bit(strap_q.style, SS_STYLE_BIT)
                      | put_bit(strap_q.refclk, SS_REFCLK_BIT);
            bank_word[SS_ADDR_HI:0] = strap_q.addr;
        end else if (pdata_q == MODE_STRAP_OVERRIDE_OFF) begin
            bank_word = put_bit(wake_b_q, MO_WAKE_B_BIT)
                      | put_bit(wake_a_q, MO_WAKE_A_BIT)
                      | put_bit(pwrdn_q, MO_PWRDN_BIT)
                      | put_bit(nand_q, MO_NAND_BIT)
                      | put_bit(gmii_q, MO_GMII_BIT);
        end else if (pdata_q == MODE_STRAP_STATUS_OFF) begin
            bank_word = put_bit(st_pwrdn, MO_PWRDN_BIT)
                      | put_bit(st_nand, MO_NAND_BIT)
                      | put_bit(st_gmii, MO_GMII_BIT);
        end else if (pdata_q == WAKE_CONTROL_OFF) begin
            bank_word[WC_SEL_HI:WC_SEL_LO] = wake_sel_q;
        end
    end

    // ************************
    // Next-state for the bank registers.
    // ************************

    // A write lands in the register pointed to by the portal address.
    always_comb begin
        style_d    = style_q;
        refclk_d   = refclk_q;
        wake_a_d   = wake_a_q;
        wake_b_d   = wake_b_q;
        pwrdn_d    = pwrdn_q;
        nand_d     = nand_q;
        gmii_d     = gmii_q;
        wake_sel_d = wake_sel_q;
        strap_d    = strap_q;

        if (!rst_b) begin
            // Straps follow the pins until reset releases, then freeze.
            strap_d    = strap_pins;
            style_d    = strap_pins.style;
            refclk_d   = strap_pins.refclk;
            wake_a_d   = 1'b0;
            wake_b_d   = 1'b0;
            pwrdn_d    = (strap_pins.mode == MODE_CODE_PWRDN);
            nand_d     = (strap_pins.mode == MODE_CODE_NAND);
            gmii_d     = (strap_pins.mode == MODE_CODE_GMII);
            wake_sel_d = WAKE_SEL_RESET;
        end else if (bank_wr) begin
            if (pdata_q == COMMON_CONTROL_OFF) begin
                style_d  = mgmt_req.wdata[CC_STYLE_BIT];
                refclk_d = mgmt_req.wdata[CC_REFCLK_BIT];
            end else if (pdata_q == MODE_STRAP_OVERRIDE_OFF) begin
                wake_b_d = mgmt_req.wdata[MO_WAKE_B_BIT];
                wake_a_d = mgmt_req.wdata[MO_WAKE_A_BIT];
                pwrdn_d  = mgmt_req.wdata[MO_PWRDN_BIT];
                nand_d   = mgmt_req.wdata[MO_NAND_BIT];
                gmii_d   = mgmt_req.wdata[MO_GMII_BIT];
            end else if (pdata_q == WAKE_CONTROL_OFF) begin
                wake_sel_d = mgmt_req.wdata[WC_SEL_HI:WC_SEL_LO];
            end
            // Status offsets fall through untouched, so writes there are lost.
        end
    end

    // ************************
    // Next-state for the portal and the read answer.
    // ************************

    // Post-increment steps the register pointer after a data move; PORTAL_DATA_INC_W steps it after writes only.
    always_comb begin
        pctrl_d  = pctrl_q;
        pdata_d  = pdata_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;

        if (!rst_b) begin
            pctrl_d = PORTAL_CTRL_RESET;
            pdata_d = PORTAL_DATA_RESET;
            rdata_d = RESERVED_READ;
        end else if (mgmt_req.wr) begin
            if (mgmt_req.addr == PORTAL_CTRL_REG) begin
                pctrl_d = mgmt_req.wdata;
            end else if (mgmt_req.addr == PORTAL_DATA_REG) begin
                if (!data_mode) begin
                    pdata_d = mgmt_req.wdata;
                end else if (mode != PORTAL_DATA_FIXED) begin
                    pdata_d = pdata_q + 16'h0001;
                end
            end
        end else if (mgmt_req.rd) begin
            rvalid_d = 1'b1;
            if (mgmt_req.addr == PORTAL_CTRL_REG) begin
                rdata_d = pctrl_q;
            end else if (mgmt_req.addr == PORTAL_DATA_REG) begin
                if (!data_mode) begin
                    rdata_d = pdata_q;
                end else begin
                    // Another device on the portal answers zero from here.
                    rdata_d = bank_rd ? bank_word : RESERVED_READ;
                    if (mode == PORTAL_DATA_INC) begin
                        pdata_d = pdata_q + 16'h0001;
                    end
                end
            end else begin
                rdata_d = RESERVED_READ;
            end
        end
    end

    // ************************
    // Registers.
    // ************************

    // Reset values are computed in the next-state logic so straps load there.
    always_ff @(posedge core_clk) begin
        style_q    <= style_d;
        refclk_q   <= refclk_d;
        wake_a_q   <= wake_a_d;
        wake_b_q   <= wake_b_d;
        pwrdn_q    <= pwrdn_d;
        nand_q     <= nand_d;
        gmii_q     <= gmii_d;
        wake_sel_q <= wake_sel_d;
        strap_q    <= strap_d;

        pctrl_q    <= pctrl_d;
        pdata_q    <= pdata_d;
        rdata_q    <= rdata_d;
        rvalid_q   <= rvalid_d;
    end

    // ************************
    // Controlled functions.
    // ************************

    // The override bits are the live controls, so a write acts at once.
    assign indicator_style_select = style_q;
    assign ref_clock_out_enable   = refclk_q;
    assign station_addr           = {ADDR_UPPER_ZERO, strap_q.addr};
    assign chip_power_down        = pwrdn_q;
    assign nand_tree_mode         = nand_q;
    assign gmii_mode              = gmii_q;

    assign mgmt_rdata             = rdata_q;
    assign mgmt_rvalid            = rvalid_q;

    // Shared pin selection for the wake outputs.
    // A new select shows on the pins one edge after it lands, so pins never glitch.
    wake_pin_mux u_wake_pin_mux (
        .core_clk           (core_clk),
        .rst_b              (rst_b),
        .wake_sel           (wake_sel_q),
        .wake_en_a          (wake_a_q),
        .wake_en_b          (wake_b_q),
        .wake_req           (wake_req),
        .indicator_one_b    (indicator_one_b),
        .intr_req_b         (intr_req_b),
        .wake_event_out_a_b (wake_event_out_a_b),
        .wake_event_out_b_b (wake_event_out_b_b)
    );

endmodule
`default_nettype wire

/* pkg/strap_bank_pkg.sv */
// Purpose: Shared constants and carrier types for the strap override and status bank.
// Assumes: Management register accesses arrive already decoded from the serial frame.
// Notes:   Operating-mode strap codes are plain defaults and may be retuned per product.
package strap_bank_pkg;

    // ************************
    // Management register numbers of the portal.
    // ************************
    localparam logic [4:0]  PORTAL_CTRL_REG   = 5'h0D;
    localparam logic [4:0]  PORTAL_DATA_REG   = 5'h0E;

    // ************************
    // Portal control field layout and modes.
    // ************************
    localparam int          PORTAL_MODE_HI    = 15;
    localparam int          PORTAL_MODE_LO    = 14;
    localparam int          PORTAL_DEV_HI     = 4;
    localparam logic [15:0] PORTAL_CTRL_RESET = 16'h0000;
    localparam logic [15:0] PORTAL_DATA_RESET = 16'h0000;
    localparam logic [4:0]  BANK_DEVICE       = 5'h02;

    typedef enum logic [1:0] {
        PORTAL_ADDRESS    = 2'b00,
        PORTAL_DATA_FIXED = 2'b01,
        PORTAL_DATA_INC   = 2'b10,
        PORTAL_DATA_INC_W = 2'b11
    } portal_mode_t;

    // ************************
    // Bank register offsets inside the device.
    // ************************
    localparam logic [15:0] COMMON_CONTROL_OFF      = 16'h0000;
    localparam logic [15:0] STRAP_STATUS_OFF        = 16'h0001;
    localparam logic [15:0] MODE_STRAP_OVERRIDE_OFF = 16'h0002;
    localparam logic [15:0] MODE_STRAP_STATUS_OFF   = 16'h0003;
    localparam logic [15:0] WAKE_CONTROL_OFF        = 16'h0010;

    // ************************
    // Field positions.
    // ************************
    localparam int          CC_STYLE_BIT      = 3;
    localparam int          CC_REFCLK_BIT     = 1;
    localparam int          SS_STYLE_BIT      = 7;
    localparam int          SS_REFCLK_BIT     = 5;
    localparam int          SS_ADDR_HI        = 2;
    localparam int          MO_WAKE_B_BIT     = 10;
    localparam int          MO_WAKE_A_BIT     = 8;
    localparam int          MO_PWRDN_BIT      = 7;
    localparam int          MO_NAND_BIT       = 4;
    localparam int          MO_GMII_BIT       = 1;
    localparam int          WC_SEL_HI         = 15;
    localparam int          WC_SEL_LO         = 14;
    localparam logic [15:0] RESERVED_READ     = 16'h0000;
    localparam logic [1:0]  WAKE_SEL_RESET    = 2'b00;
    localparam logic [1:0]  ADDR_UPPER_ZERO   = 2'b00;

    // ************************
    // Operating-mode strap codes (plain defaults).
    // ************************
    localparam logic [3:0]  MODE_CODE_PWRDN   = 4'h7;
    localparam logic [3:0]  MODE_CODE_NAND    = 4'h0;
    localparam logic [3:0]  MODE_CODE_GMII    = 4'hF;

    typedef enum logic [1:0] {
        WAKE_ONLY  = 2'b00,
        OTHER_ONLY = 2'b01,
        WAKE_BOTH  = 2'b10,
        WAKE_RSVD  = 2'b11
    } wake_sel_t;

    // ************************
    // Carrier types.
    // ************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic       style;
        logic       refclk;
        logic [2:0] addr;
        logic [3:0] mode;
    } strap_pins_t;

endpackage

/* verilog/wake_pin_mux.sv */
// Purpose: Chooses what drives the shared indicator/wake and interrupt/wake pins.
// Assumes: All pin-side signals are active low; wake request is an active-high level.
// Notes:   Outputs are registered so the pins never glitch on a select change.
`timescale 1ns/100ps
`default_nettype none
module wake_pin_mux
    import strap_bank_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic [1:0] wake_sel,
    input  wire logic       wake_en_a,
    input  wire logic       wake_en_b,
    input  wire logic       wake_req,
    input  wire logic       indicator_one_b,
    input  wire logic       intr_req_b,
    output logic            wake_event_out_a_b,
    output logic            wake_event_out_b_b
);

    logic pin_a_d;
    logic pin_a_q;
    logic pin_b_d;
    logic pin_b_q;
    logic wake_a_b;
    logic wake_b_b;

    // A disabled wake function leaves its half of the pin released high.
    always_comb begin
        wake_a_b = ~(wake_req & wake_en_a);
        wake_b_b = ~(wake_req & wake_en_b);
        case (wake_sel_t'(wake_sel))
            WAKE_ONLY: begin
                pin_a_d = wake_a_b;
                pin_b_d = wake_b_b;
            end
            OTHER_ONLY: begin
                pin_a_d = indicator_one_b;
                pin_b_d = intr_req_b;
            end
            WAKE_BOTH: begin
                pin_a_d = indicator_one_b & wake_a_b;
                pin_b_d = intr_req_b & wake_b_b;
            end
            default: begin
                // Reserved select keeps both pins idle rather than guessing.
                pin_a_d = 1'b1;
                pin_b_d = 1'b1;
            end
        endcase
    end

    // Pin registers.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pin_a_q <= 1'b1;
            pin_b_q <= 1'b1;
        end else begin
            pin_a_q <= pin_a_d;
            pin_b_q <= pin_b_d;
        end
    end

    assign wake_event_out_a_b = pin_a_q;
    assign wake_event_out_b_b = pin_b_q;

endmodule
`default_nettype wire

/* tb/strap_bank_monitor.sv */
// Purpose: Concurrent checks on the strap bank's ports.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Strap values are judged at the first edge after reset.
`timescale 1ns/100ps
`default_nettype none
module strap_bank_monitor
    import strap_bank_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire mgmt_req_t   mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic        mgmt_rvalid,
    input wire strap_pins_t strap_pins,
    input wire logic        indicator_style_select,
    input wire logic        ref_clock_out_enable,
    input wire logic [4:0]  station_addr,
    input wire logic        chip_power_down,
    input wire logic        nand_tree_mode,
    input wire logic        gmii_mode,
    input wire logic        wake_event_out_a_b,
    input wire logic        wake_event_out_b_b
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Reads are answered one edge later, and nothing else raises the answer strobe.
    a_read_answered: assert property (mgmt_req.rd && !mgmt_req.wr |=> mgmt_rvalid)
        else $error("read got no answer");
    a_answer_cause: assert property (mgmt_rvalid |-> $past(mgmt_req.rd) && $past(rst_b))
        else $error("answer without a read");
    a_rdata_holds: assert property (!mgmt_rvalid |-> $stable(mgmt_rdata))
        else $error("read data moved without an answer");
    // Controls leave reset equal to the straps sampled at the last reset edge.
    a_latched_straps: assert property ($rose(rst_b) |-> indicator_style_select == $past(strap_pins.style)
        && ref_clock_out_enable == $past(strap_pins.refclk) && station_addr == {2'b00, $past(strap_pins.addr)})
        else $error("strap controls wrong after reset");
    a_mode_from_strap: assert property ($rose(rst_b) |-> {chip_power_down, nand_tree_mode, gmii_mode} ==
        {$past(strap_pins.mode) == MODE_CODE_PWRDN, $past(strap_pins.mode) == MODE_CODE_NAND,
         $past(strap_pins.mode) == MODE_CODE_GMII}) else $error("mode controls differ from straps");
    a_addr_stable: assert property ($past(rst_b) |-> $stable(station_addr) && station_addr[4:3] == 2'b00)
        else $error("station address moved or upper bits set");
    // Without a write on the previous edge no control may move.
    a_controls_need_write: assert property ($past(rst_b) && !$past(mgmt_req.wr) |->
        $stable({indicator_style_select, ref_clock_out_enable, chip_power_down, nand_tree_mode, gmii_mode}))
        else $error("control changed without a write");
    a_wake_pins_idle: assert property ($rose(rst_b) |-> wake_event_out_a_b && wake_event_out_b_b)
        else $error("wake pins active after reset");
endmodule
bind strap_override_status_regs strap_bank_monitor strap_bank_monitor_i (
    .core_clk(core_clk), .rst_b(rst_b), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .strap_pins(strap_pins), .indicator_style_select(indicator_style_select),
    .ref_clock_out_enable(ref_clock_out_enable), .station_addr(station_addr), .chip_power_down(chip_power_down),
    .nand_tree_mode(nand_tree_mode), .gmii_mode(gmii_mode), .wake_event_out_a_b(wake_event_out_a_b),
    .wake_event_out_b_b(wake_event_out_b_b));
`default_nettype wire

/* tb/mgmt_station_model.sv */
// Purpose: Management controller model issuing register strobes.
// Assumes: Callers wait for reset release first.
// Notes:   Released address and data are inverted, so stale values never look valid.
`timescale 1ns/100ps
`default_nettype none
module mgmt_station_model
    import strap_bank_pkg::*;
(
    input  wire logic        core_clk,
    output var  mgmt_req_t   mgmt_req,
    input  wire logic [15:0] mgmt_rdata,
    input  wire logic        mgmt_rvalid
);
    int gap = 0;
    initial mgmt_req = '0;
    // One strobe per access; a slow controller idles gap cycles first.
    task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] wdata,
                          output logic [15:0] rdata, output logic ok);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        mgmt_req = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
        @(posedge core_clk);
        #1;
        mgmt_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
        ok = wr | mgmt_rvalid;
        rdata = mgmt_rdata;
    endtask
    // Device and register are set in address mode, then data moves in the chosen mode.
    task automatic mmd(input logic wr, input portal_mode_t mode, input logic [15:0] regn,
                       input logic [15:0] wdata, output logic [15:0] rdata, output logic ok);
        access(1'b1, PORTAL_CTRL_REG, {PORTAL_ADDRESS, 9'h000, BANK_DEVICE}, rdata, ok);
        access(1'b1, PORTAL_DATA_REG, regn, rdata, ok);
        access(1'b1, PORTAL_CTRL_REG, {mode, 9'h000, BANK_DEVICE}, rdata, ok);
        access(wr, PORTAL_DATA_REG, wdata, rdata, ok);
    endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the strap bank.
// Assumes: Straps are held through each reset.
// Notes:   Scenarios check the register view and the control ports.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import strap_bank_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst_b    = 1'b0;
    logic        wake_req = 1'b0;
    logic        ind_b    = 1'b1;
    logic        intr_b   = 1'b1;
    strap_pins_t straps   = '0;
    mgmt_req_t   req;
    logic [15:0] rdata, v;
    logic [4:0]  st_addr;
    logic        rvalid, style, refclk, pd, nand_m, gmii, pin_a_b, pin_b_b, ok;
    int          fail_count = 0;
    int          n_tests    = 0;
    int          cycles     = 0;
    always #10 core_clk = ~core_clk;
    // A hang counts as a mismatch.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    strap_override_status_regs strap_override_status_regs_i (.core_clk(core_clk), .rst_b(rst_b), .mgmt_req(req),
        .mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .strap_pins(straps), .wake_req(wake_req), .indicator_one_b(ind_b),
        .intr_req_b(intr_b), .indicator_style_select(style), .ref_clock_out_enable(refclk), .station_addr(st_addr),
        .chip_power_down(pd), .nand_tree_mode(nand_m), .gmii_mode(gmii), .wake_event_out_a_b(pin_a_b),
        .wake_event_out_b_b(pin_b_b));
    mgmt_station_model mgmt_station_model_i (.core_clk(core_clk), .mgmt_req(req), .mgmt_rdata(rdata),
        .mgmt_rvalid(rvalid));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [15:0] regn, output logic [15:0] rv, input portal_mode_t mode = PORTAL_DATA_FIXED);
        mgmt_station_model_i.mmd(1'b0, mode, regn, 16'h0000, rv, ok);
        chk("read answer", 16'h0001, {15'h0000, ok});
    endtask
    task automatic wr(input logic [15:0] regn, input logic [15:0] data);
        mgmt_station_model_i.mmd(1'b1, PORTAL_DATA_FIXED, regn, data, v, ok);
    endtask
    // Wake pin level from select, enable, wake level and the pin's other source.
    function automatic logic pin_exp(input logic [1:0] s, input logic en, input logic w, input logic o);
        case (s)
            2'b00: return ~(en & w);
            2'b01: return o;
            2'b10: return o & ~(en & w);
            default: return 1'b1;
        endcase
    endfunction
    // Every mode code through reset, with the four strap-loaded registers read back.
    task automatic t_straps();
        logic [3:0]  codes [3] = '{MODE_CODE_PWRDN, MODE_CODE_NAND, MODE_CODE_GMII};
        logic [15:0] m;
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            #1;
            straps = '{style: i[0], refclk: ~i[0], addr: 3'(i + 5), mode: codes[i]};
            rst_b = 1'b0;
            repeat (10) @(posedge core_clk);
            #1;
            rst_b = 1'b1;
            m = {8'h00, codes[i] == MODE_CODE_PWRDN, 2'b00, codes[i] == MODE_CODE_NAND, 2'b00,
                 codes[i] == MODE_CODE_GMII, 1'b0};
            rd(COMMON_CONTROL_OFF, v);
            chk("common_control", {12'h000, i[0], 1'b0, ~i[0], 1'b0}, v);
            rd(STRAP_STATUS_OFF, v);
            chk("strap_status", {8'h00, i[0], 1'b0, ~i[0], 2'b00, 3'(i + 5)}, v);
            rd(MODE_STRAP_OVERRIDE_OFF, v);
            chk("mode_strap_override", m, v);
            rd(MODE_STRAP_STATUS_OFF, v);
            chk("mode_strap_status", m, v);
            chk("station_addr", 16'(i + 5), {11'h000, st_addr});
        end
    endtask
    // Overrides act at once; status writes and reserved bits are dropped.
    task automatic t_override();
        wr(COMMON_CONTROL_OFF, 16'hFFFF);
        chk("style and refclk", 16'h0003, {14'h0000, style, refclk});
        rd(COMMON_CONTROL_OFF, v);
        chk("common_control", 16'h000A, v);
        wr(MODE_STRAP_OVERRIDE_OFF, 16'hFFFF);
        chk("mode controls", 16'h0007, {13'h0000, pd, nand_m, gmii});
        rd(MODE_STRAP_OVERRIDE_OFF, v);
        chk("mode_strap_override", 16'h0592, v);
        wr(STRAP_STATUS_OFF, 16'h0000);
        rd(STRAP_STATUS_OFF, v);
        chk("strap_status", 16'h0027, v);
        wr(MODE_STRAP_STATUS_OFF, 16'hFFFF);
        rd(MODE_STRAP_STATUS_OFF, v);
        chk("mode_strap_status", 16'h0002, v);
        wr(MODE_STRAP_OVERRIDE_OFF, 16'h0000);
        chk("mode controls", 16'h0000, {13'h0000, pd, nand_m, gmii});
    endtask
    // Post-increment modes, with a slow controller.
    task automatic t_increment();
        mgmt_station_model_i.gap = 3;
        wr(COMMON_CONTROL_OFF, 16'h0008);
        rd(COMMON_CONTROL_OFF, v, PORTAL_DATA_INC);
        mgmt_station_model_i.access(1'b0, PORTAL_DATA_REG, 16'h0000, v, ok);
        chk("read after increment", 16'h0027, v);
        rd(COMMON_CONTROL_OFF, v, PORTAL_DATA_INC_W);
        mgmt_station_model_i.access(1'b0, PORTAL_DATA_REG, 16'h0000, v, ok);
        chk("read without increment", 16'h0008, v);
        mgmt_station_model_i.gap = 0;
    endtask
    // All selects, wake enabled and not, each pin source active in turn.
    task automatic t_wake();
        for (int en = 0; en < 2; en++) begin
            wr(MODE_STRAP_OVERRIDE_OFF, en[0] ? 16'h0500 : 16'h0000);
            for (int s = 0; s < 4; s++) begin
                wr(WAKE_CONTROL_OFF, {s[1:0], 14'h0000});
                for (int k = 0; k < 2; k++) begin
                    wake_req = k[0];
                    ind_b = k[0];
                    intr_b = k[0];
                    repeat (2) @(posedge core_clk);
                    #1;
                    v = {15'h0000, pin_exp(s[1:0], en[0], k[0], k[0])};
                    chk("pin a", v, {15'h0000, pin_a_b});
                    chk("pin b", v, {15'h0000, pin_b_b});
                end
            end
        end
    endtask
    task automatic report_and_stop();
        $display("Checks made %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        t_straps();
        t_override();
        t_increment();
        t_wake();
        report_and_stop();
    end
endmodule
`default_nettype wire
